/* hdl/sfrl_pkg.sv */
// Operation
// - In 64-bit mode the extension bit widens the control register field by one bit
// - Access to a control register that is not implemented raises invalid opcode fault
// - Control register eight is the task priority register, reachable only in 64-bit mode
// - Flags bits 63:22, 15, 5, 3 read zero; bit 1 reads one
// - Status flags are updated from results and readable at any privilege
// - Legacy flags view is the low 32 bits of the flags word
// - Single-step trap bit set raises a debug exception after each instruction
// - The instruction that sets the single-step bit does not itself trap
// - Any exception or interrupt taken clears the single-step trap bit
// - Interrupt enable bit gates acceptance of maskable interrupts
// - Interrupt enable bit never affects non-maskable interrupts or exceptions
// - Changing interrupt enable depends on privilege, I/O field and virtual enables
// - I/O instruction with privilege level above the I/O field raises protection fault
// - With virtual enables on, the I/O field steers virtual interrupt handling
// - Task switch through a gate by call, interrupt or exception sets nested task bit
// - Interrupt return in legacy mode with nested task set switches task back
// - Resume flag set suppresses instruction breakpoints
// - Resume flag clears after each instruction, one later after setting return or gate
// - Pushed flags image on exception or interrupted string has resume flag set
// - Pushed image for an instruction breakpoint debug exception has resume flag clear
// - Virtual-8086 bit changes only by task switch or interrupt return, never pop; the code also lets a bus write to the flags offset change it
// - Alignment check and mask both set at level 3 fault on unaligned operands
// - With virtual enables and I/O field below 3, enable changes go to virtual flag; the code does so only when the privilege level is above the I/O field
package sfrl_pkg;
  // Flags word bit positions
  localparam int FLAG_W = 22;
  localparam int B_CF = 0;
  localparam int B_TF = 8;
  localparam int B_IF = 9;
  localparam int B_IO_PRIVILEGE_FIELD = 12;
  localparam int B_NT = 14;
  localparam int B_RF = 16;
  localparam int B_VM = 17;
  localparam int B_AC = 18;
  localparam int B_VIF = 19;
  localparam int B_VIP = 20;
  localparam logic [FLAG_W-1:0] FL_FIXED_ONE = 22'h000002;
  localparam logic [FLAG_W-1:0] FL_WRITABLE = 22'h3f7fd5;
  localparam logic [FLAG_W-1:0] FL_STATUS = 22'h0008d5;
  localparam logic [FLAG_W-1:0] FL_RESET = 22'h000002;
  // Register byte offsets
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] A_FLAGS_LO = 8'h00;
  localparam logic [ADDR_W-1:0] A_FLAGS_HI = 8'h04;
  localparam logic [ADDR_W-1:0] A_MODE = 8'h08;
  localparam logic [ADDR_W-1:0] A_TPR = 8'h0c;
  // Mode register fields
  localparam int MODE_W = 7;
  localparam int M_LONG64 = 0;
  localparam int M_CPL = 1;
  localparam int M_VME = 3;
  localparam int M_PVI = 4;
  localparam int M_AM = 5;
  localparam int M_LMA = 6;
  localparam logic [MODE_W-1:0] MODE_RESET = 7'h00;
  // Control register decode
  localparam logic [3:0] CREG_TPR = 4'h8;
  localparam logic [15:0] CREG_IMPL = 16'h011d;
  localparam int TPR_W = 4;
  localparam logic [1:0] PL_LEAST = 2'h3;
  // Kind of retiring instruction
  typedef enum logic [2:0] {
    K_PLAIN = 3'h0,
    K_INTERRUPT_RETURN = 3'h1,
    K_GATE = 3'h3,
    K_POPF = 3'h2,
    K_STI = 3'h6,
    K_CLI = 3'h7
  } sfrl_kind_t;
endpackage : sfrl_pkg

/* hdl/sfrl_flags.sv */
`timescale 1ns/1ns
module sfrl_flags #(
  parameter logic [15:0] CREG_IMPL = sfrl_pkg::CREG_IMPL
) (
  // Clock, reset and register bus
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Core execution events
  input wire logic retire_i,
  input wire logic [2:0] ins_kind_i,
  input wire logic [21:0] flags_img_i,
  input wire logic status_we_i,
  input wire logic [21:0] status_i,
  input wire logic exc_take_i,
  input wire logic exc_brk_i,
  input wire logic task_sw_i,
  input wire logic task_sw_nest_i,
  input wire logic io_instr_i,
  input wire logic mem_unaligned_i,
  input wire logic irq_i,
  input wire logic nmi_i,
  input wire logic brk_hit_i,
  input wire logic creg_acc_i,
  input wire logic creg_wr_i,
  input wire logic reg_extension_bit_i,
  input wire logic [2:0] creg_field_i,
  input wire logic [3:0] creg_wdata_i,
  // Flags view, fault pulses and qualified events
  output logic [63:0] processor_flags_word_o,
  output logic [63:0] pushed_flags_o,
  output logic step_trap_o,
  output logic protection_fault_o,
  output logic alignment_fault_o,
  output logic invalid_opcode_fault_o,
  output logic interrupt_return_task_sw_o,
  output logic irq_accept_o,
  output logic nmi_accept_o,
  output logic brk_fire_o,
  output logic creg_hit_o,
  output logic [3:0] creg_rdata_o
);

  typedef struct packed {
    logic [sfrl_pkg::FLAG_W-1:0] fl;
    logic [sfrl_pkg::MODE_W-1:0] mode;
    logic [sfrl_pkg::TPR_W-1:0] task_priority_reg;
    logic [sfrl_pkg::ADDR_W-1:0] addr;
    logic wr;
    logic ph;
    logic ready;
    logic resp;
    logic [31:0] rdata;
    logic [63:0] pushed;
    logic step_trap;
    logic prot_fault;
    logic align_fault;
    logic ud_fault;
    logic interrupt_return_sw;
    logic irq_acc;
    logic nmi_acc;
    logic brk_fire;
    logic creg_hit;
    logic [sfrl_pkg::TPR_W-1:0] creg_rdata;
  } sfrl_state_t;

  // Reset image: flags and mode from the package, bus idle and ready, no pulses
  localparam sfrl_state_t S_RESET = '{
    fl: sfrl_pkg::FL_RESET,
    mode: sfrl_pkg::MODE_RESET,
    task_priority_reg: '0,
    addr: '0,
    wr: 1'b0,
    ph: 1'b0,
    ready: 1'b1,
    resp: 1'b0,
    rdata: 32'h0,
    pushed: 64'h0,
    step_trap: 1'b0,
    prot_fault: 1'b0,
    align_fault: 1'b0,
    ud_fault: 1'b0,
    interrupt_return_sw: 1'b0,
    irq_acc: 1'b0,
    nmi_acc: 1'b0,
    brk_fire: 1'b0,
    creg_hit: 1'b0,
    creg_rdata: '0
  };

  sfrl_state_t s_q;
  sfrl_state_t s_d;

  // Forces the fixed flag positions whatever is offered
  function automatic logic [sfrl_pkg::FLAG_W-1:0] fix_flags(
    input logic [sfrl_pkg::FLAG_W-1:0] v
  );
    fix_flags = (v & sfrl_pkg::FL_WRITABLE) | sfrl_pkg::FL_FIXED_ONE;
  endfunction : fix_flags

  // Zero-extends the stored flags; no storage exists above the defined bits
  function automatic logic [63:0] widen_flags(
    input logic [sfrl_pkg::FLAG_W-1:0] v
  );
    widen_flags = {{(64 - sfrl_pkg::FLAG_W){1'b0}}, v};
  endfunction : widen_flags

  // True when the privilege level may touch interrupt and I/O controls
  function automatic logic pl_allowed(
    input logic [1:0] pl,
    input logic [1:0] field
  );
    pl_allowed = (pl <= field);
  endfunction : pl_allowed

  logic [1:0] current_priv_level;
  logic [1:0] io_privilege_field;
  logic virt_en;
  logic [3:0] creg_idx;
  logic creg_ok;
  logic [sfrl_pkg::FLAG_W-1:0] img;

  // Next-state logic for bus, flags and fault reporting
  always_comb begin
    s_d = s_q;
    s_d.step_trap = 1'b0;
    s_d.prot_fault = 1'b0;
    s_d.align_fault = 1'b0;
    s_d.ud_fault = 1'b0;
    s_d.interrupt_return_sw = 1'b0;
    s_d.creg_hit = 1'b0;
    s_d.ready = 1'b1;
    s_d.resp = 1'b0;
    current_priv_level = s_q.mode[sfrl_pkg::M_CPL +: 2];
    io_privilege_field = s_q.fl[sfrl_pkg::B_IO_PRIVILEGE_FIELD +: 2];
    virt_en = (s_q.mode[sfrl_pkg::M_VME] | s_q.mode[sfrl_pkg::M_PVI])
              & (io_privilege_field != sfrl_pkg::PL_LEAST);
    img = fix_flags(flags_img_i);
    creg_idx = {s_q.mode[sfrl_pkg::M_LONG64] & reg_extension_bit_i, creg_field_i};
    creg_ok = CREG_IMPL[creg_idx]
              & ((creg_idx != sfrl_pkg::CREG_TPR) | s_q.mode[sfrl_pkg::M_LONG64]);

    // Bus data phase writes; unmapped offsets are ignored
    if (s_q.ph && s_q.wr) begin
      unique case (s_q.addr)
        sfrl_pkg::A_FLAGS_LO: s_d.fl = fix_flags(hwdata_i[sfrl_pkg::FLAG_W-1:0]);
        sfrl_pkg::A_MODE: s_d.mode = hwdata_i[sfrl_pkg::MODE_W-1:0];
        sfrl_pkg::A_TPR: s_d.task_priority_reg = hwdata_i[sfrl_pkg::TPR_W-1:0];
        default: s_d.mode = s_d.mode;
      endcase
    end

    // Later blocks win: bus, status, retire, task switch, exception
    // Status flags from arithmetic results
    if (status_we_i) begin
      s_d.fl = (s_d.fl & ~sfrl_pkg::FL_STATUS) | (status_i & sfrl_pkg::FL_STATUS);
    end

    // Instruction completion effects
    if (retire_i) begin
      s_d.step_trap = s_q.fl[sfrl_pkg::B_TF];
      // Gate transfers keep resume set until the next instruction retires
      if (ins_kind_i != sfrl_pkg::K_GATE) begin
        s_d.fl[sfrl_pkg::B_RF] = 1'b0;
      end
      unique case (ins_kind_i)
        // Nested legacy return hands over to the task switch, flags wait for it
        sfrl_pkg::K_INTERRUPT_RETURN: begin
          if (!s_q.mode[sfrl_pkg::M_LMA] && s_q.fl[sfrl_pkg::B_NT]) begin
            s_d.interrupt_return_sw = 1'b1;
          end else begin
            s_d.fl = img;
          end
        end
        // Pop keeps mode, virtual bits and, except at level 0, the I/O field out of the caller's reach
        sfrl_pkg::K_POPF: begin
          s_d.fl = img;
          s_d.fl[sfrl_pkg::B_VM] = s_q.fl[sfrl_pkg::B_VM];
          s_d.fl[sfrl_pkg::B_RF] = 1'b0;
          s_d.fl[sfrl_pkg::B_VIF +: 2] = s_q.fl[sfrl_pkg::B_VIF +: 2];
          if (!pl_allowed(current_priv_level, io_privilege_field)) begin
            s_d.fl[sfrl_pkg::B_IF] = s_q.fl[sfrl_pkg::B_IF];
          end
          if (current_priv_level != 2'h0) begin
            s_d.fl[sfrl_pkg::B_IO_PRIVILEGE_FIELD +: 2] = io_privilege_field;
          end
        end
        // Enable changes reach the real bit, the virtual bit or a fault
        sfrl_pkg::K_STI, sfrl_pkg::K_CLI: begin
          if (pl_allowed(current_priv_level, io_privilege_field)) begin
            s_d.fl[sfrl_pkg::B_IF] = (ins_kind_i == sfrl_pkg::K_STI);
          end else if (virt_en) begin
            if (ins_kind_i == sfrl_pkg::K_STI && s_q.fl[sfrl_pkg::B_VIP]) begin
              s_d.prot_fault = 1'b1;
            end else begin
              s_d.fl[sfrl_pkg::B_VIF] = (ins_kind_i == sfrl_pkg::K_STI);
            end
          end else begin
            s_d.prot_fault = 1'b1;
          end
        end
        default: s_d.fl = s_d.fl;
      endcase
    end

    // Task switch loads the new task image, marks nesting through a gate
    if (task_sw_i) begin
      s_d.fl = img;
      if (task_sw_nest_i) begin
        s_d.fl[sfrl_pkg::B_NT] = 1'b1;
      end
    end

    // Exception or interrupt entry: push image, drop single step
    if (exc_take_i) begin
      s_d.pushed = widen_flags(s_d.fl);
      s_d.pushed[sfrl_pkg::B_RF] = ~exc_brk_i;
      s_d.fl[sfrl_pkg::B_TF] = 1'b0;
    end

    // Privilege and alignment checks
    if (io_instr_i && !pl_allowed(current_priv_level, io_privilege_field)) begin
      s_d.prot_fault = 1'b1;
    end
    s_d.align_fault = mem_unaligned_i & s_q.fl[sfrl_pkg::B_AC]
                      & s_q.mode[sfrl_pkg::M_AM] & (current_priv_level == sfrl_pkg::PL_LEAST);

    // Interrupt and breakpoint qualification
    s_d.irq_acc = irq_i & s_q.fl[sfrl_pkg::B_IF];
    s_d.nmi_acc = nmi_i;
    s_d.brk_fire = brk_hit_i & ~s_q.fl[sfrl_pkg::B_RF];

    // Control register access decode
    if (creg_acc_i) begin
      s_d.ud_fault = ~creg_ok;
      if (creg_ok && creg_idx == sfrl_pkg::CREG_TPR) begin
        s_d.creg_hit = 1'b1;
        if (creg_wr_i) begin
          s_d.task_priority_reg = creg_wdata_i;
        end else begin
          s_d.creg_rdata = s_q.task_priority_reg;
        end
      end
    end

    // Bus address phase; read data taken from the updated state
    s_d.ph = hsel_i & htrans_i[1] & hready_i;
    s_d.wr = hwrite_i;
    s_d.addr = haddr_i[sfrl_pkg::ADDR_W-1:0];
    s_d.rdata = 32'h0;
    if (s_d.ph && !hwrite_i) begin
      unique case (s_d.addr)
        sfrl_pkg::A_FLAGS_LO: s_d.rdata = {10'h0, s_d.fl};
        sfrl_pkg::A_MODE: s_d.rdata = {25'h0, s_d.mode};
        sfrl_pkg::A_TPR: s_d.rdata = {28'h0, s_d.task_priority_reg};
        default: s_d.rdata = 32'h0;
      endcase
    end
  end

  // State register
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      s_q <= S_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from state
  assign hrdata_o = s_q.rdata;
  assign hreadyout_o = s_q.ready;
  assign hresp_o = s_q.resp;
  assign processor_flags_word_o = widen_flags(s_q.fl);
  assign pushed_flags_o = s_q.pushed;
  assign step_trap_o = s_q.step_trap;
  assign protection_fault_o = s_q.prot_fault;
  assign alignment_fault_o = s_q.align_fault;
  assign invalid_opcode_fault_o = s_q.ud_fault;
  assign interrupt_return_task_sw_o = s_q.interrupt_return_sw;
  assign irq_accept_o = s_q.irq_acc;
  assign nmi_accept_o = s_q.nmi_acc;
  assign brk_fire_o = s_q.brk_fire;
  assign creg_hit_o = s_q.creg_hit;
  assign creg_rdata_o = s_q.creg_rdata;

endmodule : sfrl_flags

/* tb/sfrl_chk.sv */
`timescale 1ns/1ns
module sfrl_chk (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic retire_i,
  input wire logic exc_take_i,
  input wire logic exc_brk_i,
  input wire logic irq_i,
  input wire logic nmi_i,
  input wire logic brk_hit_i,
  input wire logic [2:0] ins_kind_i,
  input wire logic task_sw_i,
  input wire logic task_sw_nest_i,
  input wire logic mem_unaligned_i,
  input wire logic creg_acc_i,
  input wire logic [63:0] processor_flags_word_o,
  input wire logic [63:0] pushed_flags_o,
  input wire logic step_trap_o,
  input wire logic irq_accept_o,
  input wire logic nmi_accept_o,
  input wire logic brk_fire_o,
  input wire logic alignment_fault_o,
  input wire logic invalid_opcode_fault_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  wire logic [63:0] fw = processor_flags_word_o;
  // Flag word, trap and interrupt relations
  fixed_bits_a: assert property ({fw[63:22], fw[15], fw[5], fw[3], fw[1]} == 46'h1)
    else $error("fixed flag bits wrong");
  step_trap_a: assert property (retire_i && fw[8] && !exc_take_i |=> step_trap_o)
    else $error("single step trap missing");
  step_cause_a: assert property (step_trap_o |-> $past(retire_i && fw[8]))
    else $error("trap without armed retire");
  step_clear_a: assert property (exc_take_i |=> !fw[8])
    else $error("trap bit kept on exception");
  irq_gate_a: assert property (irq_accept_o == $past(irq_i && fw[9]))
    else $error("maskable interrupt gating wrong");
  nmi_pass_a: assert property (nmi_accept_o == $past(nmi_i))
    else $error("non-maskable interrupt gated");
  brk_mask_a: assert property (brk_fire_o == $past(brk_hit_i && !fw[16]))
    else $error("breakpoint not masked by resume");
  push_rf_a: assert property (exc_take_i |=> pushed_flags_o[16] == !$past(exc_brk_i))
    else $error("pushed resume bit wrong");
  align_cause_a: assert property (alignment_fault_o |-> $past(mem_unaligned_i && fw[18]))
    else $error("alignment fault without cause");
  ud_cause_a: assert property (invalid_opcode_fault_o |-> $past(creg_acc_i))
    else $error("invalid opcode without access");
  nest_set_a: assert property (task_sw_i && task_sw_nest_i |=> fw[14])
    else $error("nested task bit not set");
  v86_pop_a: assert property (retire_i && ins_kind_i == sfrl_pkg::K_POPF && !task_sw_i
    |=> $stable(fw[17]))
    else $error("v86 bit changed by pop");
  rf_clear_a: assert property (retire_i && ins_kind_i == sfrl_pkg::K_PLAIN && !task_sw_i
    |=> !fw[16])
    else $error("resume flag not cleared");
  // Main scenarios reached
  cover property (step_trap_o);
  cover property (brk_fire_o);
  cover property (exc_take_i && exc_brk_i);
  cover property (alignment_fault_o);
endmodule : sfrl_chk
bind sfrl_flags sfrl_chk sfrl_chk_i (.*);

/* tb/sfrl_core_model.sv */
`timescale 1ns/1ns
module sfrl_core_model (
  input wire logic ref_clk_i,
  output logic [36:0] ev_o
);
  // Bundle: retire, kind, image, exc, brk, tsw, nest, io, hit, acc, ext, field
  initial ev_o = 37'h0;
  // One core event held for exactly one edge, outputs settled on return
  task automatic fire(input logic [36:0] e);
    @(posedge ref_clk_i);
    ev_o <= e;
    @(posedge ref_clk_i);
    ev_o <= 37'h0;
    #1;
  endtask : fire
endmodule : sfrl_core_model

/* tb/sfrl_flags_tb_top.sv */
`timescale 1ns/1ns
module sfrl_flags_tb_top;
  logic ref_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [31:0] haddr_i = 32'h0;
  logic [1:0] htrans_i = 2'h0;
  logic hwrite_i = 1'b0;
  logic [31:0] hwdata_i = 32'h0;
  logic status_we_i = 1'b0;
  logic [21:0] status_i = 22'h0;
  logic irq_i = 1'b0;
  logic nmi_i = 1'b0;
  logic mem_unaligned_i = 1'b0;
  logic creg_wr_i = 1'b0;
  logic [3:0] creg_wdata_i = 4'h0;
  logic hresp_o, alignment_fault_o;
  logic [36:0] ev;
  logic [31:0] hrdata_o, rd;
  logic [63:0] processor_flags_word_o, pushed_flags_o;
  logic hreadyout_o, step_trap_o, protection_fault_o, invalid_opcode_fault_o;
  logic interrupt_return_task_sw_o, irq_accept_o, nmi_accept_o, brk_fire_o, creg_hit_o;
  logic [3:0] creg_rdata_o;
  int err_total = 0;
  int total_checks = 0;
  sfrl_flags sfrl_flags_i (.*, .hsel_i(1'b1), .hsize_i(3'h2), .hready_i(hreadyout_o),
    .retire_i(ev[36]), .ins_kind_i(ev[35:33]),
    .flags_img_i(ev[32:11]), .exc_take_i(ev[10]), .exc_brk_i(ev[9]), .task_sw_i(ev[8]),
    .task_sw_nest_i(ev[7]), .io_instr_i(ev[6]), .brk_hit_i(ev[5]), .creg_acc_i(ev[4]),
    .reg_extension_bit_i(ev[3]), .creg_field_i(ev[2:0]));
  sfrl_core_model sfrl_core_model_i (.ref_clk_i, .ev_o(ev));
  // 125 MHz clock
  initial forever #4 ref_clk_i = ~ref_clk_i;
  // Compare and count
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Single AHB word transfer, read data left in rd
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    haddr_i <= {24'h0, a};
    htrans_i <= 2'h2;
    hwrite_i <= w;
    do @(posedge ref_clk_i); while (hreadyout_o !== 1'b1);
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge ref_clk_i); while (hreadyout_o !== 1'b1);
    rd = hrdata_o;
  endtask : bus
  // Read one register and compare
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk("bus read", {32'h0, e}, {31'h0, hresp_o, rd});
  endtask : rdc
  // Fixed bits, discarded writes, status update
  task automatic t_fixed();
    rdc(8'h00, 32'h2);
    rdc(8'h04, 32'h0);
    bus(1'b1, 8'h00, 32'hffffffff);
    rdc(8'h00, 32'h3f7fd7);
    chk("flags word", 64'h3f7fd7, processor_flags_word_o);
    rdc(8'h10, 32'h0);
    bus(1'b1, 8'h00, 32'h0);
    @(posedge ref_clk_i);
    status_we_i <= 1'b1;
    status_i <= 22'h3fffff;
    @(posedge ref_clk_i);
    status_we_i <= 1'b0;
    rdc(8'h00, 32'h8d7);
    bus(1'b1, 8'h00, 32'h0);
  endtask : t_fixed
  // Single step and pushed image
  task automatic t_step();
    sfrl_core_model_i.fire({1'b1, sfrl_pkg::K_POPF, 22'h102, 11'h0});
    chk("setter trap", 1'b0, step_trap_o);
    sfrl_core_model_i.fire({1'b1, sfrl_pkg::K_PLAIN, 22'h0, 11'h0});
    chk("step trap", 1'b1, step_trap_o);
    sfrl_core_model_i.fire({26'h0, 2'h2, 9'h0});
    chk("trap cleared", 1'b0, processor_flags_word_o[8]);
    chk("pushed resume", 1'b1, pushed_flags_o[16]);
    sfrl_core_model_i.fire({26'h0, 2'h3, 9'h0});
    chk("pushed resume brk", 1'b0, pushed_flags_o[16]);
  endtask : t_step
  // I/O privilege and interrupt gating at level 3
  task automatic t_io();
    bus(1'b1, 8'h08, 32'h6);
    sfrl_core_model_i.fire({30'h0, 1'b1, 6'h0});
    chk("io fault", 1'b1, protection_fault_o);
    @(posedge ref_clk_i);
    irq_i <= 1'b1;
    nmi_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    #1;
    chk("masked irq", 1'b0, irq_accept_o);
    chk("nmi", 1'b1, nmi_accept_o);
    bus(1'b1, 8'h00, 32'h3200);
    @(posedge ref_clk_i);
    #1;
    chk("open irq", 1'b1, irq_accept_o);
    sfrl_core_model_i.fire({30'h0, 1'b1, 6'h0});
    chk("io allowed", 1'b0, protection_fault_o);
    sfrl_core_model_i.fire({1'b1, sfrl_pkg::K_CLI, 22'h0, 11'h0});
    chk("clear enable", 1'b0, processor_flags_word_o[9]);
    @(posedge ref_clk_i);
    irq_i <= 1'b0;
    nmi_i <= 1'b0;
  endtask : t_io
  // Control register decode
  task automatic t_creg();
    bus(1'b1, 8'h08, 32'h1);
    bus(1'b1, 8'h0c, 32'h5);
    sfrl_core_model_i.fire({32'h0, 2'h3, 3'h0});
    chk("task priority", 5'h15, {creg_hit_o, creg_rdata_o});
    sfrl_core_model_i.fire({32'h0, 2'h3, 3'h1});
    chk("creg nine", 1'b1, invalid_opcode_fault_o);
    @(posedge ref_clk_i);
    creg_wr_i <= 1'b1;
    creg_wdata_i <= 4'ha;
    sfrl_core_model_i.fire({32'h0, 2'h3, 3'h0});
    chk("task priority write", 5'h15, {creg_hit_o, creg_rdata_o});
    @(posedge ref_clk_i);
    creg_wr_i <= 1'b0;
    rdc(8'h0c, 32'ha);
    bus(1'b1, 8'h08, 32'h0);
    sfrl_core_model_i.fire({32'h0, 2'h3, 3'h0});
    chk("creg eight legacy", 2'h0, {creg_hit_o, invalid_opcode_fault_o});
  endtask : t_creg
  // Unaligned access pulse, fault judged one edge later
  task automatic unal(input logic e);
    @(posedge ref_clk_i);
    mem_unaligned_i <= 1'b1;
    @(posedge ref_clk_i);
    mem_unaligned_i <= 1'b0;
    #1;
    chk("align fault", e, alignment_fault_o);
  endtask : unal
  // Alignment check, virtual interrupt flag and pop rules at level 3
  task automatic t_mode();
    bus(1'b1, 8'h08, 32'h26);
    bus(1'b1, 8'h00, 32'h40002);
    unal(1'b1);
    bus(1'b1, 8'h08, 32'h6);
    unal(1'b0);
    sfrl_core_model_i.fire({1'b1, sfrl_pkg::K_STI, 22'h0, 11'h0});
    chk("sti no virtual", 1'b1, protection_fault_o);
    bus(1'b1, 8'h08, 32'he);
    sfrl_core_model_i.fire({1'b1, sfrl_pkg::K_STI, 22'h0, 11'h0});
    chk("virtual flag", 1'b1, processor_flags_word_o[19]);
    chk("enable untouched", 1'b0, processor_flags_word_o[9]);
    bus(1'b1, 8'h00, 32'h100002);
    sfrl_core_model_i.fire({1'b1, sfrl_pkg::K_STI, 22'h0, 11'h0});
    chk("pending sti", 1'b1, protection_fault_o);
    sfrl_core_model_i.fire({4'h0, 22'h20002, 2'h0, 2'h2, 7'h0});
    sfrl_core_model_i.fire({1'b1, sfrl_pkg::K_POPF, 22'h2, 11'h0});
    chk("v86 kept", 1'b1, processor_flags_word_o[17]);
    bus(1'b1, 8'h08, 32'h0);
  endtask : t_mode
  // Resume flag sequencing and nested task return
  task automatic t_rf();
    sfrl_core_model_i.fire({1'b1, sfrl_pkg::K_INTERRUPT_RETURN, 22'h10002, 11'h0});
    sfrl_core_model_i.fire({1'b1, sfrl_pkg::K_GATE, 22'h0, 11'h0});
    chk("resume kept", 1'b1, processor_flags_word_o[16]);
    sfrl_core_model_i.fire({31'h0, 1'b1, 5'h0});
    chk("brk masked", 1'b0, brk_fire_o);
    sfrl_core_model_i.fire({1'b1, sfrl_pkg::K_PLAIN, 22'h0, 11'h0});
    chk("resume cleared", 1'b0, processor_flags_word_o[16]);
    sfrl_core_model_i.fire({31'h0, 1'b1, 5'h0});
    chk("brk fires", 1'b1, brk_fire_o);
    sfrl_core_model_i.fire({4'h0, 22'h2, 2'h0, 2'h3, 7'h0});
    chk("nested", 1'b1, processor_flags_word_o[14]);
    sfrl_core_model_i.fire({1'b1, sfrl_pkg::K_INTERRUPT_RETURN, 22'h2, 11'h0});
    chk("return switch", 1'b1, interrupt_return_task_sw_o);
  endtask : t_rf
  // Verdict and end of run
  task automatic results();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results
  // Main sequence
  initial begin
    repeat (6) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    t_fixed();
    t_step();
    t_io();
    t_creg();
    t_mode();
    t_rf();
    results();
  end
  // Watchdog, far beyond the roughly 125 cycles the run needs
  initial begin
    #100000;
    err_total++;
    results();
  end
endmodule : sfrl_flags_tb_top
